// *** verilog/slcm_map.vh ***
/*
 Constant map for the serial link clock and mode configuration block.
 Assumes inclusion by the block's design files only; definitions only.
*/
`ifndef SLCM_MAP_VH
`define SLCM_MAP_VH
// Register byte addresses
`define SLCM_ADDR_CTRL 8'h00
`define SLCM_ADDR_STATUS 8'h04
`define SLCM_ADDR_PLLCFG 8'h08
`define SLCM_ADDR_ID 8'h0C
// Control register fields
`define SLCM_CTRL_RATE 0
`define SLCM_CTRL_PRESC 1
`define SLCM_CTRL_WIDTH 2
`define SLCM_CTRL_BYPASS 3
`define SLCM_CTRL_CE_N 4
`define SLCM_CTRL_SRC 5
`define SLCM_CTRL_RESET 32'h0000_0000
// Status register fields
`define SLCM_ST_BYPASS 0
`define SLCM_ST_FULL 1
`define SLCM_ST_FULL_OE 2
`define SLCM_ST_RX_OUT 3
`define SLCM_ST_TX_SRC 4
`define SLCM_ST_RATE 5
`define SLCM_ST_PRESC 6
`define SLCM_ST_WIDTH 7
// PLL configuration fields
`define SLCM_PLL_MUL_LSB 0
`define SLCM_PLL_DIV_LSB 8
// Rate bands in MBaud
`define SLCM_BAND_HI_MIN 100
`define SLCM_BAND_HI_MAX 200
`define SLCM_BAND_LO_MIN 50
`define SLCM_BAND_LO_MAX 100
// Multiplier for 8-bit and 10-bit characters, divider per band
`define SLCM_MUL_NARROW 8'h0A
`define SLCM_MUL_WIDE 8'h0C
`define SLCM_DIV_HI 8'h01
`define SLCM_DIV_LO 8'h02
// Arbitrary identification value
`define SLCM_ID_VALUE 32'h5A5A_0001
// Settle counter value at which the state moves on, after three cycles in the settle state, before flags drive
`define SLCM_SETTLE_COUNT 2'h2
`endif

// *** verilog/slcm_sync2.v ***
/*
 Two-stage level synchroniser for asynchronous pin inputs.
 Assumes clk and rst_n of the destination domain.
*/
`timescale 1ns/10ps
module slcm_sync2 #(
	parameter W = 1
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // slcm_sync2

// *** verilog/slcm_top.v ***
/*
 Clock and mode configuration of a serial link transceiver: strap decoding,
 prescaler, PLL setting derivation, clock source selection and transmit
 full toggling, with an AHB-Lite register slave.
 Assumes clk is the reference clock at 125 MHz and straps are asynchronous.
 Straps are treated as static; a change shows a few cycles later.
 The register source select can override the straps at run time.
 Transmit flags only drive once the settle state has passed, since
 the synchroniser still shows reset zeros for its first two cycles.
 A single bus master is assumed; hready is the slave's own hreadyout.
 Clock muxes are behavioural and need glitch-free cells in the netlist.
*/
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "slcm_map.vh"
module slcm_top #(
	parameter BYPASS_ACTIVE_HIGH = 0
) (
	input wire clk,
	input wire rst_n,
	input wire clk_en,
	input wire rate_band_select,
	input wire prescaler_select,
	input wire parallel_width_select,
	input wire fifo_bypass_strap,
	input wire chip_enable_n,
	input wire transmit_write_clock,
	input wire fifo_transmit_full,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	output wire pll_reference_clock,
	output wire transmit_pll_clock,
	output wire transmit_port_clock,
	output reg [7:0] pll_multiplier,
	output reg [7:0] pll_divider,
	output reg transmit_full_flag,
	output reg transmit_full_oe,
	output reg receive_clock_is_output,
	output reg fifo_bypass_active,
	output reg [31:0] rate_band_min,
	output reg [31:0] rate_band_max
);
	localparam ST_IDLE = 3'h1;
	localparam ST_SETTLE = 3'h2;
	localparam ST_RUN = 3'h4;

	wire [4:0] pin_sync;
	reg [31:0] ctrl;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [1:0] settle_cnt;
	wire [7:0] status_bits;
	reg presc_div;
	reg toggle;
	reg ce_ref;
	reg wr_pend;
	reg rd_pend;
	reg [7:0] addr_q;
	wire eff_rate;
	wire eff_presc;
	wire eff_width;
	wire eff_bypass_raw;
	wire eff_ce_n;
	wire bypass;
	wire toggle_mode;
	wire [7:0] next_mul;
	wire [7:0] next_div;
	wire full_src;

	slcm_sync2 #(.W(5)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(clk_en),
		.d({chip_enable_n, fifo_bypass_strap, parallel_width_select,
			prescaler_select, rate_band_select}),
		.q(pin_sync)
	);

	function eff_pick;
		input use_reg;
		input reg_bit;
		input pin_bit;
		begin
			eff_pick = use_reg ? reg_bit : pin_bit;
		end
	endfunction

	// Software source select lets tests steer the mode without moving straps
	assign eff_rate = eff_pick(ctrl[`SLCM_CTRL_SRC], ctrl[`SLCM_CTRL_RATE], pin_sync[0]);
	assign eff_presc = eff_pick(ctrl[`SLCM_CTRL_SRC], ctrl[`SLCM_CTRL_PRESC], pin_sync[1]);
	assign eff_width = eff_pick(ctrl[`SLCM_CTRL_SRC], ctrl[`SLCM_CTRL_WIDTH], pin_sync[2]);
	assign eff_bypass_raw = eff_pick(ctrl[`SLCM_CTRL_SRC], ctrl[`SLCM_CTRL_BYPASS], pin_sync[3]);
	assign eff_ce_n = eff_pick(ctrl[`SLCM_CTRL_SRC], ctrl[`SLCM_CTRL_CE_N], pin_sync[4]);
	assign bypass = (BYPASS_ACTIVE_HIGH != 0) ? eff_bypass_raw : ~eff_bypass_raw;

	function [7:0] pll_mul;
		input width8;
		begin
			case (width8)
			1'h1: pll_mul = `SLCM_MUL_NARROW;
			default: pll_mul = `SLCM_MUL_WIDE;
			endcase
		end
	endfunction

	function [31:0] band_limit;
		input rate_hi;
		input upper;
		begin
			case ({rate_hi, upper})
			2'h3: band_limit = `SLCM_BAND_HI_MAX;
			2'h2: band_limit = `SLCM_BAND_HI_MIN;
			2'h1: band_limit = `SLCM_BAND_LO_MAX;
			default: band_limit = `SLCM_BAND_LO_MIN;
			endcase
		end
	endfunction

	function bus_take;
		input sel;
		input [1:0] trans;
		input rdy;
		begin
			// Only NONSEQ and SEQ carry a transfer
			bus_take = sel & trans[1] & rdy;
		end
	endfunction

	function [7:0] pll_div;
		input rate_hi;
		input presc;
		begin
			// Halved reference is compensated by a smaller divider
			if (rate_hi)
				pll_div = `SLCM_DIV_HI;
			else if (presc)
				pll_div = `SLCM_DIV_HI;
			else
				pll_div = `SLCM_DIV_LO;
		end
	endfunction

	assign next_mul = pll_mul(eff_width);
	assign next_div = pll_div(eff_rate, eff_presc);

	assign pll_reference_clock = clk;
	// Clock muxing here is behavioural; a glitch-free cell belongs in the netlist
	assign transmit_pll_clock = eff_presc ? presc_div : clk;
	assign transmit_port_clock = bypass ? clk : transmit_write_clock;
	assign toggle_mode = bypass & (eff_presc | ~eff_rate);
	assign full_src = bypass ? (toggle_mode ? toggle : 1'b0) : fifo_transmit_full;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_div <= 1'b0;
		end else if (clk_en) begin
			presc_div <= ~presc_div;
		end
	end

	always @* begin
		case (state)
		ST_IDLE: next_state = ST_SETTLE;
		ST_SETTLE: begin
			if (settle_cnt == `SLCM_SETTLE_COUNT)
				next_state = ST_RUN;
			else
				next_state = ST_SETTLE;
		end
		ST_RUN: next_state = ST_RUN;
		default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			settle_cnt <= 2'h0;
		end else if (clk_en) begin
			state <= next_state;
			if (state == ST_SETTLE)
				settle_cnt <= settle_cnt + 2'h1;
			else
				settle_cnt <= 2'h0;
		end
	end

	// Toggle restarts low whenever the mode leaves, so the first edge is predictable
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle <= 1'b0;
			ce_ref <= 1'b0;
		end else if (clk_en) begin
			toggle <= toggle_mode ? ~toggle : 1'b0;
			ce_ref <= ~eff_ce_n;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pll_multiplier <= 8'h00;
			pll_divider <= 8'h00;
		end else if (clk_en) begin
			pll_multiplier <= next_mul;
			pll_divider <= next_div;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_full_flag <= 1'b0;
			transmit_full_oe <= 1'b0;
		end else if (clk_en) begin
			transmit_full_flag <= (state == ST_RUN) ? full_src : 1'b0;
			// Flags float while disabled; in every mode enable follows the chip enable once in run
			transmit_full_oe <= (state == ST_RUN) & ce_ref;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_clock_is_output <= 1'b0;
			fifo_bypass_active <= 1'b0;
		end else if (clk_en) begin
			receive_clock_is_output <= bypass;
			fifo_bypass_active <= bypass;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_band_min <= 32'h0000_0000;
			rate_band_max <= 32'h0000_0000;
		end else if (clk_en) begin
			rate_band_min <= band_limit(eff_rate, 1'b0);
			rate_band_max <= band_limit(eff_rate, 1'b1);
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign status_bits = {eff_width, eff_presc, eff_rate, bypass, receive_clock_is_output,
		transmit_full_oe, transmit_full_flag, fifo_bypass_active};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
		end else if (clk_en && hready) begin
			wr_pend <= bus_take(hsel, htrans, hready) & hwrite;
			rd_pend <= bus_take(hsel, htrans, hready) & ~hwrite;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 8'h00;
		end else if (clk_en && hready) begin
			addr_q <= haddr[7:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		// Upper control bits are not implemented and read as zero
		if (!rst_n) begin
			ctrl <= `SLCM_CTRL_RESET;
		end else if (clk_en && wr_pend && addr_q == `SLCM_ADDR_CTRL) begin
			ctrl <= {26'h000_0000, hwdata[5:0]};
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en && bus_take(hsel, htrans, hready) && !hwrite) begin
			case (haddr[7:0])
			`SLCM_ADDR_CTRL: hrdata <= ctrl;
			`SLCM_ADDR_STATUS: hrdata <= {24'h00_0000, status_bits};
			`SLCM_ADDR_PLLCFG: hrdata <= {16'h0000, pll_divider, pll_multiplier};
			`SLCM_ADDR_ID: hrdata <= `SLCM_ID_VALUE;
			default: hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // slcm_top

// *** test/slcm_properties.sv ***
/* Port checker for slcm_top, bound after the module.
 Assumes the default bypass polarity (strap low bypasses). */
`timescale 1ns/10ps
module slcm_props (
	input wire clk,
	input wire rst_n,
	input wire rate_band_select,
	input wire prescaler_select,
	input wire parallel_width_select,
	input wire fifo_bypass_strap,
	input wire chip_enable_n,
	input wire transmit_write_clock,
	input wire fifo_transmit_full,
	input wire transmit_pll_clock,
	input wire transmit_port_clock,
	input wire [7:0] pll_multiplier,
	input wire [7:0] pll_divider,
	input wire transmit_full_flag,
	input wire transmit_full_oe,
	input wire fifo_bypass_active
);
	reg [3:0] age;
	wire [4:0] st = {rate_band_select, prescaler_select, parallel_width_select,
		fifo_bypass_strap, chip_enable_n};
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			age <= 4'h0;
		else if (age != 4'hF)
			age <= age + 4'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Straps held long enough for the two-flop sync and the state to settle
	sequence s_q;
		(age == 4'hF && $stable(st))[*6];
	endsequence
	a_mul_width: assert property (s_q |-> pll_multiplier ==
		(parallel_width_select ? 8'h0A : 8'h0C)) else $error("multiplier");
	a_div_band: assert property (s_q |-> pll_divider ==
		((rate_band_select | prescaler_select) ? 8'h01 : 8'h02)) else $error("divider");
	a_bypass_level: assert property (s_q |-> fifo_bypass_active == !fifo_bypass_strap)
		else $error("bypass level");
	a_oe_enable: assert property (s_q |-> transmit_full_oe == !chip_enable_n)
		else $error("full enable");
	a_full_toggle: assert property (s_q ##0 fifo_bypass_active &&
		(prescaler_select | !rate_band_select) |=> $changed(transmit_full_flag)) else $error("toggle");
	a_full_follow: assert property (s_q ##0 !fifo_bypass_active |=>
		transmit_full_flag == $past(fifo_transmit_full)) else $error("full follow");
	a_port_source: assert property (s_q |-> transmit_port_clock ==
		(fifo_bypass_active ? clk : transmit_write_clock)) else $error("port clock");
	a_presc_half: assert property (s_q ##0 prescaler_select |=>
		$changed(transmit_pll_clock)) else $error("prescaler");
endmodule // slcm_props
bind slcm_top slcm_props u_props (.clk, .rst_n, .rate_band_select, .prescaler_select,
	.parallel_width_select, .fifo_bypass_strap, .chip_enable_n, .transmit_write_clock,
	.fifo_transmit_full, .transmit_pll_clock, .transmit_port_clock, .pll_multiplier,
	.pll_divider, .transmit_full_flag, .transmit_full_oe, .fifo_bypass_active);

// *** test/slcm_host_model.sv ***
/* Host side: free-running write clock and transmit FIFO full flag.
 Assumes clk is the device reference clock. */
`timescale 1ns/10ps
module slcm_host_model (
	input wire clk,
	output reg transmit_write_clock,
	output reg fifo_transmit_full
);
	// Off-grid period so the port clock source is told apart from clk
	initial transmit_write_clock = 1'h0;
	always #7.3 transmit_write_clock = ~transmit_write_clock;
	initial fifo_transmit_full = 1'h0;
	always @(posedge clk)
		fifo_transmit_full <= $urandom;
endmodule // slcm_host_model

// *** test/slcm_top_tb.sv ***
/* Bench for slcm_top: strap sweep, AHB reads, reset.
 Assumes the design and the host model are compiled first. */
`timescale 1ns/10ps
module slcm_top_tb;
	reg clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
	reg rate_band_select = 0, prescaler_select = 0, parallel_width_select = 0;
	reg fifo_bypass_strap = 1, chip_enable_n = 1;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, v, q;
	wire transmit_write_clock, fifo_transmit_full, hreadyout, transmit_full_flag, hresp;
	wire [31:0] rate_band_max;
	wire transmit_full_oe, receive_clock_is_output, fifo_bypass_active;
	wire [7:0] pll_multiplier, pll_divider;
	wire [31:0] hrdata, rate_band_min;
	integer num_errors = 0, check_count = 0, cyc = 0, i;
	reg f;
	always #4 clk = ~clk;
	slcm_host_model host_u (.clk, .transmit_write_clock, .fifo_transmit_full);
	slcm_top dut_u (.clk, .rst_n, .clk_en(1'h1), .rate_band_select, .prescaler_select,
		.parallel_width_select, .fifo_bypass_strap, .chip_enable_n, .transmit_write_clock,
		.fifo_transmit_full, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pll_reference_clock(),
		.transmit_pll_clock(), .transmit_port_clock(), .pll_multiplier, .pll_divider,
		.transmit_full_flag, .transmit_full_oe, .receive_clock_is_output,
		.fifo_bypass_active, .rate_band_min, .rate_band_max);
	function [31:0] f_pll(input r, input p, input w);
		f_pll = {16'h0000, (r | p) ? 8'h01 : 8'h02, w ? 8'h0A : 8'h0C};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task ahb(input wr, input [31:0] a, input [31:0] d, output [31:0] r);
		begin
			hsel <= 1'h1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= wr;
			@(posedge clk);
			while (hreadyout !== 1'h1)
				@(posedge clk);
			hsel <= 1'h0;
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk);
			while (hreadyout !== 1'h1)
				@(posedge clk);
			r = hrdata;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			num_errors = num_errors + 1;
			finish_test;
		end
	end
	initial begin
		q = $urandom(56);
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		for (i = 0; i < 24; i = i + 1) begin
			v = (i < 16) ? i : $urandom;
			@(posedge clk);
			{chip_enable_n, fifo_bypass_strap, parallel_width_select, prescaler_select,
				rate_band_select} <= v[4:0];
			repeat (10) @(posedge clk);
			#1;
			chk({16'h0000, pll_divider, pll_multiplier}, f_pll(v[0], v[1], v[2]));
			chk(rate_band_min, v[0] ? 32'h0000_0064 : 32'h0000_0032);
			chk(rate_band_max, v[0] ? 32'h0000_00C8 : 32'h0000_0064);
			chk({31'h0000_0000, hresp}, 32'h0000_0000);
			chk({30'h0000_0000, receive_clock_is_output, fifo_bypass_active},
				{30'h0000_0000, ~v[3], ~v[3]});
			chk({31'h0000_0000, transmit_full_oe}, {31'h0000_0000, ~v[4]});
			f = transmit_full_flag;
			@(posedge clk);
			#1;
			if (!v[3] && (v[1] || !v[0]))
				chk({31'h0000_0000, transmit_full_flag}, {31'h0000_0000, ~f});
			ahb(1'h0, 32'h0000_0008, 32'h0000_0000, q);
			chk(q, f_pll(v[0], v[1], v[2]));
		end
		ahb(1'h1, 32'h0000_0018, $urandom, q);
		ahb(1'h0, 32'h0000_0018, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		ahb(1'h1, 32'h0000_0000, 32'h0000_001F, q);
		ahb(1'h0, 32'h0000_0000, 32'h0000_0000, q);
		chk(q, 32'h0000_001F);
		rst_n <= 1'h0;
		@(posedge clk);
		#1;
		chk({16'h0000, pll_divider, pll_multiplier}, 32'h0000_0000);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		finish_test;
	end
endmodule // slcm_top_tb
